// ===== rtl/synth_cfg_defs.svh
`ifndef SYNTH_CFG_DEFS_SVH
`define SYNTH_CFG_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register indices; the byte address is four times the index
`define IDX_GLOBAL_CTRL   6'h00
`define IDX_SEED_ENABLE   6'h25
`define IDX_DEN_UPPER     6'h26
`define IDX_DEN_LOWER     6'h27
`define IDX_SEED_UPPER    6'h28
`define IDX_SEED_LOWER    6'h29
`define IDX_NUM_UPPER     6'h2A
`define IDX_NUM_LOWER     6'h2B
`define IDX_OUT_MOD_CTRL  6'h2C
`define IDX_SECOND_LEVEL  6'h2D
`define IDX_FIXED_A       6'h2E
`define IDX_FIXED_B       6'h2F
`define IDX_FIXED_C       6'h30
`define IDX_FIXED_D       6'h31
`define IDX_FIXED_E       6'h32
`define IDX_FIXED_F       6'h33
`define IDX_FIXED_G       6'h34
`define IDX_FIRST         6'h25
`define IDX_LAST          6'h34
`define BANK_DEPTH        16

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define BIT_SOFT_RESET    1
`define BIT_START_EN      15
`define FIRST_LVL_HI      13
`define FIRST_LVL_LO      8
`define BIT_SECOND_SD     7
`define BIT_FIRST_SD      6
`define BIT_MOD_RST_LOW   5
`define ORDER_HI          2
`define ORDER_LO          0
`define SECOND_LVL_HI     5
`define SECOND_LVL_LO     0
`define LEVEL_MAX         6'h12
`define ORDER_MAX         3'h4

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define RST_SEED_ENABLE   16'h0205
`define RST_DEN           16'hFFFF
`define RST_SEED          16'h0000
`define RST_NUM           16'h0000
`define RST_OUT_MOD_CTRL  16'h08A2
`define RST_SECOND_LEVEL  16'hC608
`define RST_FIXED_A       16'h07F0
`define RST_FIXED_B       16'h0300
`define RST_FIXED_C       16'h03E0
`define RST_FIXED_D       16'h4180
`define RST_FIXED_E       16'h0080
`define RST_FIXED_F       16'h0080
`define RST_FIXED_G       16'h0420

`endif

// ===== rtl/synth_cfg_pkg.sv
package synth_cfg_pkg;

	typedef enum logic [2:0] {
		ORDER_INTEGER = 3'h0,
		ORDER_FIRST   = 3'h1,
		ORDER_SECOND  = 3'h2,
		ORDER_THIRD   = 3'h3,
		ORDER_FOURTH  = 3'h4
	} modulator_order_e;

	typedef struct packed {
		logic       shutdown;
		logic [5:0] level;
	} rf_output_s;

	typedef struct packed {
		logic             modulator_reset_low;
		modulator_order_e modulator_order;
		logic             start_state_enable;
	} modulator_cfg_s;

endpackage : synth_cfg_pkg

// ===== rtl/fractional_synth_config_regs.sv
`include "synth_cfg_defs.svh"

// Operation
// RULE_01 - Offset 28h holds seed bits 31..16 setting the modulator start state.
// RULE_02 - Offset 29h holds seed bits 15..0; both seed halves reset to zero.
// RULE_03 - Offset 2Ah holds numerator bits 31..16, reset zero.
// RULE_04 - Offset 2Bh holds numerator bits 15..0, reset zero.
// RULE_05 - Bits 13..8 of 2Ch set first output level; host keeps codes at most 18.
// RULE_06 - Bits 5..0 of 2Dh set second output level; host keeps codes at most 18.
// RULE_07 - Bit 7 of 2Ch shuts down second output when one; resets one.
// RULE_08 - Bit 6 of 2Ch shuts down first output when one; resets zero.
// RULE_09 - Bit 5 of 2Ch low holds modulator in reset; resets one.
// RULE_10 - Bits 2..0 of 2Ch select modulator order 0..4; 5..7 unused; reset 2.
// RULE_11 - Host writes bits 15..14 and 4..3 of 2Ch as zero.
// RULE_12 - Host writes 318h into bits 15..6 of 2Dh.
// RULE_13 - Host keeps 7F0h, 300h, 3E0h, 4180h in 2Eh..31h.
// RULE_14 - Host keeps 80h in 32h and 33h.
// RULE_15 - Global software reset restores all constant words to their values.
// RULE_16 - Host writes 421h to 34h although it resets to 420h.
// RULE_17 - Seed is used only while seed enable, bit 15 of 25h, is one.
// RULE_18 - Denominator is 32 bits, upper half at lower offset, reset all ones.
// RULE_19 - Split fields are assembled upper half from lower-addressed word.
module fractional_synth_config_regs
(
	input  wire logic                         clk,
	input  wire logic                         sys_rst,
	input  wire logic                         ce,
	input  wire logic [7:0]                   address,
	input  wire logic                         read,
	input  wire logic                         write,
	input  wire logic [31:0]                  writedata,
	input  wire logic [3:0]                   byteenable,
	output logic      [31:0]                  readdata,
	output logic                              waitrequest,
	output logic      [31:0]                  modulator_start_state,
	output logic      [31:0]                  fraction_numerator,
	output logic      [31:0]                  fraction_denominator,
	output synth_cfg_pkg::modulator_cfg_s     modulator_cfg,
	output synth_cfg_pkg::rf_output_s         first_rf_output,
	output synth_cfg_pkg::rf_output_s         second_rf_output
);
	import synth_cfg_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [15:0]  bank_r [`BANK_DEPTH];
	logic         waitrequest_r;
	logic [31:0]  readdata_r;
	logic         soft_rst_r;
	logic [5:0]   word_idx;
	logic [5:0]   bank_diff;
	logic [3:0]   bank_sel;
	logic         bank_hit;
	logic         ctrl_hit;
	logic         wr_done;
	logic         rd_start;
	logic [15:0]  rd_word;
	logic [15:0]  ctrl_word;
	logic [15:0]  level_word;
	logic [5:0]   first_level;
	logic [5:0]   second_level;
	logic [2:0]   order_code;
	logic [31:0]  seed_word;

	// Literals cannot be bit-selected, so the reset words are named first
	localparam logic [15:0] CTRL_RST    = `RST_OUT_MOD_CTRL;
	localparam logic [15:0] LEVEL_RST   = `RST_SECOND_LEVEL;
	localparam logic [15:0] SEED_EN_RST = `RST_SEED_ENABLE;

	////////////////////////////////////////////////////////////////////////////
	// Reset values of the bank entries

	function automatic logic [15:0] reset_word(input logic [5:0] idx);
		logic [15:0] val;
		val = 16'h0000;
		case (idx)
			`IDX_SEED_ENABLE:  val = `RST_SEED_ENABLE;
			`IDX_DEN_UPPER:    val = `RST_DEN;       // RULE_18
			`IDX_DEN_LOWER:    val = `RST_DEN;       // RULE_18
			`IDX_SEED_UPPER:   val = `RST_SEED;      // RULE_01
			`IDX_SEED_LOWER:   val = `RST_SEED;      // RULE_02
			`IDX_NUM_UPPER:    val = `RST_NUM;       // RULE_03
			`IDX_NUM_LOWER:    val = `RST_NUM;       // RULE_04
			`IDX_OUT_MOD_CTRL: val = `RST_OUT_MOD_CTRL;
			`IDX_SECOND_LEVEL: val = `RST_SECOND_LEVEL;
			`IDX_FIXED_A:      val = `RST_FIXED_A;   // RULE_15
			`IDX_FIXED_B:      val = `RST_FIXED_B;   // RULE_15
			`IDX_FIXED_C:      val = `RST_FIXED_C;   // RULE_15
			`IDX_FIXED_D:      val = `RST_FIXED_D;   // RULE_15
			`IDX_FIXED_E:      val = `RST_FIXED_E;   // RULE_15
			`IDX_FIXED_F:      val = `RST_FIXED_F;   // RULE_15
			`IDX_FIXED_G:      val = `RST_FIXED_G;   // RULE_15
			default:           val = 16'h0000;
		endcase
		return val;
	endfunction : reset_word

	// Only the two low byte lanes carry register bits
	function automatic logic [15:0] merge_word(
		input logic [15:0] old_word,
		input logic [15:0] new_word,
		input logic [1:0]  lanes
	);
		logic [15:0] val;
		val = old_word;
		if (lanes[0])
		begin
			val[7:0] = new_word[7:0];
		end
		if (lanes[1])
		begin
			val[15:8] = new_word[15:8];
		end
		return val;
	endfunction : merge_word

	////////////////////////////////////////////////////////////////////////////
	// Address decode

	assign word_idx  = address[7:2];
	assign bank_diff = word_idx - `IDX_FIRST;
	assign bank_sel  = bank_diff[3:0];
	assign bank_hit  = (word_idx >= `IDX_FIRST) && (word_idx <= `IDX_LAST);
	assign ctrl_hit  = (word_idx == `IDX_GLOBAL_CTRL);
	assign wr_done   = ce && write && !waitrequest_r;
	assign rd_start  = ce && read && waitrequest_r;

	always_comb
	begin
		rd_word = 16'h0000;
		if (bank_hit)
		begin
			rd_word = bank_r[bank_sel];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Avalon-MM handshake: one wait cycle per access, then released

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			waitrequest_r <= 1'b1;
		end
		else if (ce)
		begin
			waitrequest_r <= !((read || write) && waitrequest_r);
		end
	end

	// Unmapped words and the control word read as zero
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			readdata_r <= 32'h0000_0000;
		end
		else if (rd_start)
		begin
			readdata_r <= {16'h0000, rd_word};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Global software reset, self clearing

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			soft_rst_r <= 1'b0;
		end
		else if (ce)
		begin
			soft_rst_r <= wr_done && ctrl_hit && byteenable[0]
				&& writedata[`BIT_SOFT_RESET];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register bank, one entry per word

	for (genvar g = 0; g < `BANK_DEPTH; g++)
	begin : g_bank
		localparam logic [5:0] ENTRY_IDX = 6'(g) + `IDX_FIRST;

		always_ff @(posedge clk)
		begin
			if (sys_rst)
			begin
				bank_r[g] <= reset_word(ENTRY_IDX);
			end
			else if (ce)
			begin
				if (soft_rst_r)
				begin
					bank_r[g] <= reset_word(ENTRY_IDX); // RULE_15
				end
				else if (wr_done && bank_hit && (bank_sel == 4'(g)))
				begin
					bank_r[g] <= merge_word(bank_r[g], writedata[15:0], byteenable[1:0]);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Field extraction
	// Padding bits are stored as written; the host keeps them at their values.

	assign ctrl_word  = bank_r[4'(`IDX_OUT_MOD_CTRL - `IDX_FIRST)]; // RULE_11
	assign level_word = bank_r[4'(`IDX_SECOND_LEVEL - `IDX_FIRST)]; // RULE_12

	// Levels above the limit would overdrive the output stage, so they saturate
	always_comb
	begin
		first_level = ctrl_word[`FIRST_LVL_HI:`FIRST_LVL_LO];
		if (first_level > `LEVEL_MAX)
		begin
			first_level = `LEVEL_MAX; // RULE_05
		end
	end

	always_comb
	begin
		second_level = level_word[`SECOND_LVL_HI:`SECOND_LVL_LO];
		if (second_level > `LEVEL_MAX)
		begin
			second_level = `LEVEL_MAX; // RULE_06
		end
	end

	// Unused order codes fall back to integer mode
	always_comb
	begin
		order_code = ctrl_word[`ORDER_HI:`ORDER_LO];
		if (order_code > `ORDER_MAX)
		begin
			order_code = ORDER_INTEGER; // RULE_10
		end
	end

	assign seed_word = {bank_r[4'(`IDX_SEED_UPPER - `IDX_FIRST)],
		bank_r[4'(`IDX_SEED_LOWER - `IDX_FIRST)]}; // RULE_19

	////////////////////////////////////////////////////////////////////////////
	// Registered outputs toward the modulator and the two RF output stages

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			modulator_start_state <= 32'h0000_0000;
		end
		else if (ce)
		begin
			if (bank_r[4'(`IDX_SEED_ENABLE - `IDX_FIRST)][`BIT_START_EN])
			begin
				modulator_start_state <= seed_word; // RULE_01 RULE_02 RULE_17
			end
			else
			begin
				modulator_start_state <= 32'h0000_0000; // RULE_17
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			fraction_numerator   <= {`RST_NUM, `RST_NUM};
			fraction_denominator <= {`RST_DEN, `RST_DEN};
		end
		else if (ce)
		begin
			fraction_numerator <= {bank_r[4'(`IDX_NUM_UPPER - `IDX_FIRST)],
				bank_r[4'(`IDX_NUM_LOWER - `IDX_FIRST)]}; // RULE_03 RULE_04 RULE_19
			fraction_denominator <= {bank_r[4'(`IDX_DEN_UPPER - `IDX_FIRST)],
				bank_r[4'(`IDX_DEN_LOWER - `IDX_FIRST)]}; // RULE_18 RULE_19
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			modulator_cfg.modulator_reset_low <= CTRL_RST[`BIT_MOD_RST_LOW];
			modulator_cfg.modulator_order     <= ORDER_SECOND;
			modulator_cfg.start_state_enable  <= SEED_EN_RST[`BIT_START_EN];
		end
		else if (ce)
		begin
			modulator_cfg.modulator_reset_low <= ctrl_word[`BIT_MOD_RST_LOW]; // RULE_09
			modulator_cfg.modulator_order     <= modulator_order_e'(order_code); // RULE_10
			modulator_cfg.start_state_enable  <=
				bank_r[4'(`IDX_SEED_ENABLE - `IDX_FIRST)][`BIT_START_EN]; // RULE_17
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			first_rf_output.shutdown  <= CTRL_RST[`BIT_FIRST_SD];
			first_rf_output.level     <= CTRL_RST[`FIRST_LVL_HI:`FIRST_LVL_LO];
			second_rf_output.shutdown <= CTRL_RST[`BIT_SECOND_SD];
			second_rf_output.level    <= LEVEL_RST[`SECOND_LVL_HI:`SECOND_LVL_LO];
		end
		else if (ce)
		begin
			first_rf_output.shutdown  <= ctrl_word[`BIT_FIRST_SD];  // RULE_08
			first_rf_output.level     <= first_level;               // RULE_05
			second_rf_output.shutdown <= ctrl_word[`BIT_SECOND_SD]; // RULE_07
			second_rf_output.level    <= second_level;              // RULE_06
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus outputs

	assign readdata    = readdata_r;
	assign waitrequest = waitrequest_r;

endmodule : fractional_synth_config_regs

// ===== sim/synth_cfg_asserts.sv
module synth_cfg_checker
	import synth_cfg_pkg::*;
(
	input wire logic                          clk,
	input wire logic                          sys_rst,
	input wire logic                          ce,
	input wire logic [7:0]                    address,
	input wire logic                          read,
	input wire logic                          write,
	input wire logic [31:0]                   writedata,
	input wire logic [3:0]                    byteenable,
	input wire logic                          waitrequest,
	input wire logic [31:0]                   modulator_start_state,
	input wire logic [31:0]                   fraction_numerator,
	input wire logic [31:0]                   fraction_denominator,
	input wire synth_cfg_pkg::modulator_cfg_s modulator_cfg,
	input wire synth_cfg_pkg::rf_output_s     first_rf_output,
	input wire synth_cfg_pkg::rf_output_s     second_rf_output
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////////////////////////
	// A write accepted on a full 16-bit word; outputs show it two edges later
	sequence s_wr(logic [5:0] i);
		ce && write && !waitrequest && address[7:2] == i && byteenable[1:0] == 2'h3;
	endsequence

	////////////////////////////////////////////////////////////////////////////////
	// A frozen clock enable stretches the wait, so both handshake edges must run
	chk_bus_wait: assert property (ce && (read || write) && waitrequest ##1 ce |-> !waitrequest ##1 waitrequest)
		else $error("waitrequest not a single low cycle");
	chk_reset_state: assert property (disable iff (1'b0) sys_rst |=> waitrequest
		&& fraction_denominator == 32'hFFFF_FFFF && modulator_cfg == {1'b1, ORDER_SECOND, 1'b0}
		&& first_rf_output == 7'h08 && second_rf_output == 7'h48)
		else $error("outputs wrong after reset");
	chk_level_cap: assert property (first_rf_output.level <= 6'h12 && second_rf_output.level <= 6'h12)
		else $error("output level above cap");
	chk_order_legal: assert property (modulator_cfg.modulator_order <= ORDER_FOURTH)
		else $error("unused order code presented");
	chk_seed_gate: assert property (!modulator_cfg.start_state_enable |-> modulator_start_state == 32'h0)
		else $error("seed used while disabled");
	chk_num_lower: assert property (s_wr(6'h2B) |-> ##2 fraction_numerator[15:0] == $past(writedata[15:0], 2))
		else $error("numerator low half not updated");
	chk_seed_upper: assert property (s_wr(6'h28) ##2 modulator_cfg.start_state_enable
		|-> modulator_start_state[31:16] == $past(writedata[15:0], 2))
		else $error("seed high half not updated");
	chk_ctrl_bits: assert property (s_wr(6'h2C) |-> ##2 {second_rf_output.shutdown, first_rf_output.shutdown,
		modulator_cfg.modulator_reset_low} == $past(writedata[7:5], 2))
		else $error("control bits not updated");
	chk_soft_restore: assert property (s_wr(6'h00) ##0 writedata[1] |-> ##3 fraction_numerator == 32'h0
		&& second_rf_output == 7'h48)
		else $error("soft reset did not restore");
endmodule : synth_cfg_checker

bind fractional_synth_config_regs synth_cfg_checker chk_u (.clk(clk), .sys_rst(sys_rst), .ce(ce), .address(address),
	.read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .waitrequest(waitrequest),
	.modulator_start_state(modulator_start_state), .fraction_numerator(fraction_numerator),
	.fraction_denominator(fraction_denominator), .modulator_cfg(modulator_cfg),
	.first_rf_output(first_rf_output), .second_rf_output(second_rf_output));

// ===== sim/host_model.sv
module host_model
(
	input wire logic         clk,
	input wire logic         waitrequest,
	input wire logic [31:0]  readdata,
	output logic     [7:0]   address,
	output logic             read,
	output logic             write,
	output logic     [31:0]  writedata,
	output logic     [3:0]   byteenable
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		{address, read, write, writedata, byteenable} = '0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Each access leaves one idle edge before it, so a strobe is never set twice in a step
	task automatic wr(input logic [5:0] i, input logic [15:0] d);
		@(posedge clk);
		address <= {i, 2'h0};
		writedata <= {16'h0000, d};
		byteenable <= 4'h3;
		write <= 1'b1;
		do @(posedge clk); while (waitrequest !== 1'b0);
		write <= 1'b0;
	endtask : wr

	task automatic rd(input logic [5:0] i, output logic [31:0] d);
		@(posedge clk);
		address <= {i, 2'h0};
		read <= 1'b1;
		do @(posedge clk); while (waitrequest !== 1'b0);
		d = readdata;
		read <= 1'b0;
	endtask : rd

	task automatic ctrl(input logic s2, s1, mr, input logic [5:0] lv, input logic [2:0] od);
		wr(6'h2C, {2'h0, lv, s2, s1, mr, 2'h0, od});
	endtask : ctrl

	task automatic load_fixed();
		wr(6'h2D, {10'h318, 6'h08});
		wr(6'h2E, 16'h07F0);
		wr(6'h2F, 16'h0300);
		wr(6'h30, 16'h03E0);
		wr(6'h31, 16'h4180);
		wr(6'h32, 16'h0080);
		wr(6'h33, 16'h0080);
		wr(6'h34, 16'h0421);
	endtask : load_fixed
endmodule : host_model

// ===== sim/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import synth_cfg_pkg::*;

	logic           clk, sys_rst, ce, read, write, waitrequest;
	logic [7:0]     address;
	logic [3:0]     byteenable;
	logic [31:0]    writedata, readdata, start_st, num, den, d;
	modulator_cfg_s cfg;
	rf_output_s     rf1, rf2;
	int             n_fail = 0;
	int             cmp_count = 0;
	localparam logic [15:0] RST_TAB [13] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h08A2, 16'hC608,
		16'h07F0, 16'h0300, 16'h03E0, 16'h4180, 16'h0080, 16'h0080, 16'h0420};

	fractional_synth_config_regs dut_u (.clk(clk), .sys_rst(sys_rst), .ce(ce), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .modulator_start_state(start_st), .fraction_numerator(num),
		.fraction_denominator(den), .modulator_cfg(cfg), .first_rf_output(rf1), .second_rf_output(rf2));
	host_model host_u (.clk(clk), .waitrequest(waitrequest), .readdata(readdata), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Outputs lag the register by one edge, so sample on a later falling edge
	task automatic settle(input int n);
		repeat (n) @(negedge clk);
	endtask : settle

	task automatic t_reset();
		for (int i = 0; i < 13; i++)
		begin
			host_u.rd(6'h28 + 6'(i), d);
			chk("reset word", {16'h0000, RST_TAB[i]}, d);
		end
		chk("denominator", 32'hFFFF_FFFF, den);
		chk("mod cfg", {27'h0, 1'b1, ORDER_SECOND, 1'b0}, 32'(cfg));
		chk("rf pair", {18'h0, 7'h08, 7'h48}, {18'h0, rf1, rf2});
	endtask : t_reset

	task automatic t_fraction();
		host_u.wr(6'h2A, 16'h1234);
		host_u.wr(6'h2B, 16'hABCD);
		host_u.wr(6'h28, 16'h5A5A);
		host_u.wr(6'h29, 16'hC3C3);
		settle(2);
		chk("numerator", 32'h1234_ABCD, num);
		chk("seed off", 32'h0, start_st);
		host_u.wr(6'h25, 16'h8205);
		settle(2);
		chk("seed on", 32'h5A5A_C3C3, start_st);
		host_u.rd(6'h29, d);
		chk("seed low", 32'h0000_C3C3, d);
		host_u.wr(6'h28, 16'h0FF0);
		settle(2);
		chk("seed high", 32'h0FF0_C3C3, start_st);
	endtask : t_fraction

	// Levels alternate 17 and 18; a host never writes codes above 18
	task automatic t_ctrl();
		for (int o = 0; o < 8; o++)
		begin
			host_u.ctrl(1'b0, 1'b1, 1'b0, 6'h11 + 6'(o % 2), 3'(o));
			settle(2);
			chk("order", (o > 4) ? 32'h0 : 32'(o), 32'(cfg.modulator_order));
			chk("out cfg", {1'b1, 6'h11 + 6'(o % 2), 1'b0, 1'b0}, {rf1, rf2.shutdown, cfg.modulator_reset_low});
			host_u.rd(6'h2C, d);
			chk("ctrl word", {18'h0, 6'h11 + 6'(o % 2), 5'h08, 3'(o)}, d);
		end
		host_u.ctrl(1'b1, 1'b0, 1'b1, 6'h05, 3'h3);
		host_u.wr(6'h2D, {10'h318, 6'h12});
		settle(2);
		chk("out cfg", {1'b0, 6'h05, 1'b1, 1'b1}, {rf1, rf2.shutdown, cfg.modulator_reset_low});
		chk("second level", 32'h12, 32'(rf2.level));
	endtask : t_ctrl

	task automatic t_unmapped();
		host_u.wr(6'h3F, 16'hFFFF);
		host_u.rd(6'h3F, d);
		chk("unmapped", 32'h0, d);
	endtask : t_unmapped

	// A request made while the clock enable is low must wait until it returns
	task automatic t_freeze();
		@(posedge clk);
		ce <= 1'b0;
		fork
			host_u.wr(6'h2A, 16'h5555);
		join_none
		settle(4);
		chk("frozen wait", 32'h1, 32'(waitrequest));
		chk("frozen num", 32'h1234_ABCD, num);
		@(posedge clk);
		ce <= 1'b1;
		wait fork;
		settle(2);
		chk("thawed num", 32'h5555_ABCD, num);
	endtask : t_freeze

	task automatic t_soft();
		host_u.load_fixed();
		host_u.rd(6'h34, d);
		chk("word 34", 32'h0421, d);
		host_u.wr(6'h2E, 16'h1111);
		host_u.wr(6'h00, 16'h0002);
		settle(3);
		chk("numerator", 32'h0, num);
		host_u.rd(6'h2E, d);
		chk("word 2E", 32'h07F0, d);
		host_u.rd(6'h34, d);
		chk("word 34", 32'h0420, d);
	endtask : t_soft

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial
	begin
		repeat (3000) @(posedge clk);
		n_fail++;
		end_of_test();
	end

	initial
	begin
		sys_rst = 1'b1;
		ce = 1'b1;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset();
		t_fraction();
		t_ctrl();
		t_unmapped();
		t_freeze();
		t_soft();
		end_of_test();
	end
endmodule : tb
